/* logic/tsnc_consts.svh */
// register offsets, field positions and reset values for the trap status block
`ifndef TSNC_CONSTS_SVH
`define TSNC_CONSTS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define TSNC_TRAP_STATUS_CONTROL_OFS 12'h000
`define TSNC_ADDR_W 12

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define TSNC_NESTING_OFF_BIT 15
`define TSNC_ARITH_FAULT_BIT 4
`define TSNC_ADDR_FAULT_BIT 3
`define TSNC_STACK_FAULT_BIT 2
`define TSNC_CLOCK_LOSS_BIT 1
`define TSNC_FLAG_LSB 1
`define TSNC_FLAG_MSB 4

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define TSNC_RESET_NESTING 1'h0
`define TSNC_RESET_FLAGS 4'h0

`endif

/* logic/tsnc_pkg.sv */
// types shared by the trap status and nesting control block
package tsnc_pkg;

    // apb request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } tsnc_apb_req_t;

    // trap events from the core, one bit each, bit 3 = arithmetic ... bit 0 = clock loss
    typedef struct packed {
        logic arith;
        logic addr;
        logic stack;
        logic clock_loss;
    } tsnc_traps_t;

    // state of one hardware settable flag
    typedef struct packed {
        logic flag;
    } tsnc_flag_state_t;

    // state of the top module
    typedef struct packed {
        logic        nesting_off;
        logic [31:0] prdata;
        logic        pslverr;
    } tsnc_state_t;

endpackage

/* logic/tsnc_flag.sv */
// one sticky trap status flag: hardware sets, software writes
`timescale 1ns/1ps
module tsnc_flag (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // hardware set and software write
    input wire logic set_event,
    input wire logic sw_write,
    input wire logic sw_value,
    // flag value
    output logic flag
);

    tsnc_pkg::tsnc_flag_state_t st;
    tsnc_pkg::tsnc_flag_state_t next_st;

    // set wins over a software clear in the same cycle so no trap is lost
    always_comb begin
        next_st = st;
        if (sw_write) begin
            next_st.flag = sw_value;
        end
        if (set_event) begin
            next_st.flag = 1'h1;
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st.flag <= 1'h0;
        end else begin
            st <= next_st;
        end
    end

    assign flag = st.flag;

    chk_flag_set_sticks: assert property (@(posedge clk) disable iff (!rst_n)
        set_event |=> flag)
        else $error("flag not set after trap event");
    chk_flag_holds_value: assert property (@(posedge clk) disable iff (!rst_n)
        (!set_event && !sw_write) |=> $stable(flag))
        else $error("flag changed alone");

endmodule // tsnc_flag

/* logic/tsnc_top.sv */
// trap status and interrupt nesting control register behind an apb slave
`timescale 1ns/1ps
`include "tsnc_consts.svh"
module tsnc_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // trap events from the core, one-cycle pulses on clk
    input wire logic trap_arith,
    input wire logic trap_addr,
    input wire logic trap_stack,
    input wire logic trap_clock_loss,
    // controls toward the interrupt logic
    output logic nesting_off,
    output logic [3:0] trap_flags
);

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    tsnc_pkg::tsnc_apb_req_t req;
    tsnc_pkg::tsnc_traps_t traps;
    tsnc_pkg::tsnc_state_t st;
    tsnc_pkg::tsnc_state_t next_st;
    logic hit;
    logic wr_acc;
    logic [15:0] reg_view;

    // gather the bus and the trap sources into their carriers
    assign req = '{
        psel: psel,
        penable: penable,
        pwrite: pwrite,
        paddr: paddr,
        pwdata: pwdata
    };
    assign traps = '{
        arith: trap_arith,
        addr: trap_addr,
        stack: trap_stack,
        clock_loss: trap_clock_loss
    };

    // only one word is mapped; anything else answers with an error
    assign hit = (req.paddr == `TSNC_TRAP_STATUS_CONTROL_OFS);
    // a write takes effect only at the access edge of a mapped address
    assign wr_acc = req.psel && req.penable && req.pwrite && hit;
    // zero wait states: the slave is always ready
    assign pready = 1'h1;

    // ---------------------------------------------------------------
    // trap status flags
    // ---------------------------------------------------------------
    // one flag per trap source, index 0 is bit 1 of the register
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_flag
            tsnc_flag u_flag (
                .clk(clk),
                .rst_n(rst_n),
                .set_event(traps[g]),
                .sw_write(wr_acc),
                .sw_value(req.pwdata[`TSNC_FLAG_LSB + g]),
                .flag(trap_flags[g])
            );

            // a plain write lands in its flag bit at the access edge
            chk_flag_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
                (wr_acc && !traps[g]) |=> trap_flags[g] == $past(pwdata[`TSNC_FLAG_LSB + g]))
                else $error("flag write lost");
            // a trap beside a clearing write still leaves the flag set
            chk_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
                (wr_acc && traps[g]) |=> trap_flags[g])
                else $error("trap lost to a write");
            // a read shows the flag as it stood at the setup edge
            chk_flag_reads_back: assert property (@(posedge clk) disable iff (!rst_n)
                (psel && !penable && !pwrite && hit)
                |=> prdata[`TSNC_FLAG_LSB + g] == $past(trap_flags[g]))
                else $error("read data does not show flag");
        end
    endgenerate

    // assemble the readable view; unimplemented bits are constant zero
    always_comb begin
        reg_view = 16'h0000;
        reg_view[`TSNC_NESTING_OFF_BIT] = st.nesting_off;
        reg_view[`TSNC_FLAG_MSB:`TSNC_FLAG_LSB] = trap_flags;
    end

    // ---------------------------------------------------------------
    // control state and read data
    // ---------------------------------------------------------------
    // read data is registered at the setup cycle so it stands in the access phase;
    // the trade-off is that a read shows the flags as they were one edge before
    // the access edge, so a trap in the access cycle shows up on the next read;
    // the nesting control changes only at the access edge of a mapped write
    always_comb begin
        next_st = st;
        if (wr_acc) begin
            next_st.nesting_off = req.pwdata[`TSNC_NESTING_OFF_BIT];
        end
        if (req.psel && !req.penable) begin
            next_st.prdata = (hit && !req.pwrite) ? {16'h0000, reg_view} : 32'h0000_0000;
            next_st.pslverr = !hit;
        end
    end

    // register the state; reset clears the nesting control
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st.nesting_off <= `TSNC_RESET_NESTING;
            st.prdata <= 32'h0000_0000;
            st.pslverr <= 1'h0;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pslverr = st.pslverr && psel && penable;
    assign nesting_off = st.nesting_off;

    // ---------------------------------------------------------------
    // checks: nesting control
    // ---------------------------------------------------------------
    // a write lands, nothing else moves it, and a read shows it
    chk_nest_write_takes: assert property (@(posedge clk) disable iff (!rst_n)
        wr_acc |=> nesting_off == $past(pwdata[15]))
        else $error("nesting bit missed write");
    chk_nest_holds: assert property (@(posedge clk) disable iff (!rst_n)
        !wr_acc |=> $stable(nesting_off))
        else $error("nesting bit changed alone");
    chk_nest_reads_back: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && hit) |=> prdata[15] == $past(nesting_off))
        else $error("read data does not show nesting bit");

    // ---------------------------------------------------------------
    // checks: trap flags
    // ---------------------------------------------------------------
    // each trap pulse sets its own flag at the next edge
    chk_arith_sets: assert property (@(posedge clk) disable iff (!rst_n)
        trap_arith |=> trap_flags[3])
        else $error("arith flag not set");
    chk_addr_sets: assert property (@(posedge clk) disable iff (!rst_n)
        trap_addr |=> trap_flags[2])
        else $error("addr flag not set");
    chk_stack_sets: assert property (@(posedge clk) disable iff (!rst_n)
        trap_stack |=> trap_flags[1])
        else $error("stack flag not set");
    chk_clock_loss_sets: assert property (@(posedge clk) disable iff (!rst_n)
        trap_clock_loss |=> trap_flags[0])
        else $error("clock loss flag not set");

    // with no trap and no write a flag keeps its value
    chk_arith_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (!trap_arith && !wr_acc) |=> $stable(trap_flags[3]))
        else $error("arith flag changed alone");
    chk_addr_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (!trap_addr && !wr_acc) |=> $stable(trap_flags[2]))
        else $error("addr flag changed alone");
    chk_stack_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (!trap_stack && !wr_acc) |=> $stable(trap_flags[1]))
        else $error("stack flag changed alone");
    chk_clock_loss_holds: assert property (@(posedge clk) disable iff (!rst_n)
        (!trap_clock_loss && !wr_acc) |=> $stable(trap_flags[0]))
        else $error("clock loss flag changed alone");

    // reset clears everything; software may clear a flag; reads show the flags
    chk_flags_reset: assert property (@(posedge clk)
        !rst_n |=> (trap_flags == 4'h0 && nesting_off == 1'h0))
        else $error("bad reset");
    chk_flag_sw_clear: assert property (@(posedge clk) disable iff (!rst_n)
        (wr_acc && !trap_arith && !pwdata[4]) |=> !trap_flags[3])
        else $error("arith flag clear lost");
    chk_read_flags: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && !penable && !pwrite && hit) |=> prdata[4:1] == $past(trap_flags))
        else $error("read data does not show flags");

    // ---------------------------------------------------------------
    // checks: unused bits and unmapped addresses
    // ---------------------------------------------------------------
    // unused bits read zero; an unmapped address is refused and changes nothing
    chk_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && !pwrite && hit)
        |-> (prdata[14:5] == 10'h000 && prdata[0] == 1'h0 && prdata[31:16] == 16'h0000))
        else $error("unimplemented bits not zero");
    chk_unmapped_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && pwrite && !hit && traps == 4'h0)
        |=> ($stable(trap_flags) && $stable(nesting_off)))
        else $error("unmapped write changed the register");
    chk_bad_addr_error: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && !hit) |-> (pslverr && prdata == 32'h0000_0000))
        else $error("unmapped access not refused");
    chk_good_addr_no_error: assert property (@(posedge clk) disable iff (!rst_n)
        (psel && penable && hit) |-> !pslverr)
        else $error("mapped access refused");

    // ---------------------------------------------------------------
    // scenarios the bench is expected to reach
    // ---------------------------------------------------------------
    cov_nest_set: cover property (@(posedge clk) disable iff (!rst_n)
        wr_acc && pwdata[15]);
    cov_trap_and_clear: cover property (@(posedge clk) disable iff (!rst_n)
        wr_acc && trap_stack && !pwdata[2]);
    cov_read_flag: cover property (@(posedge clk) disable iff (!rst_n)
        psel && penable && !pwrite && prdata[4]);
    cov_bad_addr: cover property (@(posedge clk) disable iff (!rst_n)
        pslverr);
    cov_all_flags: cover property (@(posedge clk) disable iff (!rst_n)
        trap_flags == 4'hf);

endmodule // tsnc_top

/* test/tsnc_core_model.sv */
// core-side model: turns trap requests into one-cycle trap pulses
`timescale 1ns/1ps
module tsnc_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // trap requests, [3]=arith .. [0]=clock loss
    input wire logic [3:0] fire,
    // trap pulses toward the block
    output logic trap_arith,
    output logic trap_addr,
    output logic trap_stack,
    output logic trap_clock_loss
);
    logic [3:0] fire_d;
    // edge detect: a held request still gives one pulse, as the core does
    always_ff @(posedge clk) begin
        fire_d <= rst_n ? fire : 4'h0;
    end
    // one pulse per trap kind
    assign {trap_arith, trap_addr, trap_stack, trap_clock_loss} = fire & ~fire_d;
endmodule // tsnc_core_model

/* test/tsnc_top_tb_top.sv */
// self-checking bench for the trap status and nesting control register
`timescale 1ns/1ps
`include "tsnc_consts.svh"
module tsnc_top_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] fire = 4'h0;
    logic t_ar, t_ad, t_st, t_cl;
    logic nesting_off;
    logic [3:0] trap_flags;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int comparisons = 0;
    localparam logic [31:0] ALL = (32'h1 << `TSNC_NESTING_OFF_BIT) | (32'hf << `TSNC_FLAG_LSB);
    localparam logic [11:0] REG = `TSNC_TRAP_STATUS_CONTROL_OFS;

    always #4 clk = ~clk;

    tsnc_core_model core (.clk(clk), .rst_n(rst_n), .fire(fire), .trap_arith(t_ar),
        .trap_addr(t_ad), .trap_stack(t_st), .trap_clock_loss(t_cl));
    tsnc_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .trap_arith(t_ar), .trap_addr(t_ad), .trap_stack(t_st), .trap_clock_loss(t_cl),
        .nesting_off(nesting_off), .trap_flags(trap_flags));

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task automatic finish_test();
        $display("compares %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // apb cycle: setup, then access until pready is seen high at a rising edge;
    // the answer is taken at that edge, before the design updates its registers
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            n_fail++;
            finish_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [31:0] exp);
        apb(1'b0, REG, 32'h0);
        check(rd, exp);
    endtask

    // ---------------------------------------------------------------
    // tests
    // ---------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(32'h0);
        $display("test reset values done");
        apb(1'b1, REG, 32'hffffffff);
        rd_chk(ALL);
        check({31'h0, nesting_off}, 32'h1);
        apb(1'b1, REG, 32'h0);
        rd_chk(32'h0);
        $display("test software access done");
        // each trap alone sets only its own flag, software clears it again
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            fire <= 4'h1 << i;
            @(posedge clk);
            fire <= 4'h0;
            @(negedge clk);
            @(negedge clk);
            check({28'h0, trap_flags}, 32'h1 << i);
            rd_chk(32'h1 << (i + `TSNC_FLAG_LSB));
            apb(1'b1, REG, 32'h0);
            rd_chk(32'h0);
        end
        $display("test trap flags done");
        // a stack trap in the access cycle of a clearing write keeps its flag
        fork
            apb(1'b1, REG, 32'h0);
            begin
                repeat (2) @(posedge clk);
                fire <= 4'h2;
                @(posedge clk);
                fire <= 4'h0;
            end
        join
        @(negedge clk);
        check({28'h0, trap_flags}, 32'h2);
        rd_chk(32'h1 << `TSNC_STACK_FAULT_BIT);
        apb(1'b1, REG, 32'h0);
        rd_chk(32'h0);
        $display("test set over clear done");
        apb(1'b1, 12'h004, 32'hffffffff);
        check({31'h0, er}, 32'h1);
        check(rd, 32'h0);
        rd_chk(32'h0);
        $display("test unmapped address done");
        apb(1'b1, REG, 32'hffffffff);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        rd_chk(32'h0);
        $display("test second reset done");
        finish_test();
    end
endmodule // tsnc_top_tb_top
